// File: logic/flash_wp_pkg.sv
package flash_wp_pkg;

    // ==========================================================
    // Register map, byte addresses
    localparam logic [11:0] PROTECT_OFFSET = 12'h000;
    localparam logic [11:0] KEY_OFFSET = 12'h004;
    localparam logic [11:0] STATUS_OFFSET = 12'h008;

    // ==========================================================
    // Field layout
    localparam int UNLOCK_BIT = 31;
    localparam int BOUNDARY_WIDTH = 24;
    localparam logic [7:0] FLASH_PREFIX = 8'h1d;

    // ==========================================================
    // Reset values
    localparam logic UNLOCK_RESET = 1'b1;
    localparam logic [23:0] BOUNDARY_RESET = 24'h00_0000;

    // ==========================================================
    // Unlock key words, values arbitrary
    localparam logic [31:0] KEY_FIRST_WORD = 32'h3c5a_0f96;
    localparam logic [31:0] KEY_SECOND_WORD = 32'hc3a5_f069;

    // ==========================================================
    // Unlock sequence states
    typedef enum logic [1:0] {
        KEY_IDLE,
        KEY_FIRST,
        KEY_ARMED
    } key_state_type;

endpackage : flash_wp_pkg

// File: logic/protect_check_if.sv
`timescale 1ns/10ps

interface protect_check_if;
    logic [23:0] boundary;
    logic [31:0] addr;
    logic hit;

    modport owner (output boundary, output addr, input hit);
    modport checker_side (input boundary, input addr, output hit);
endinterface : protect_check_if

// File: logic/page_protect_check.sv
`timescale 1ns/10ps

module page_protect_check #(
    parameter int PAGE_BITS = 12
) (
    // Boundary and address under test
    protect_check_if.checker_side chk
);
    import flash_wp_pkg::*;

    logic [23:0] addr_page;
    logic [23:0] bnd_page;

    // ==========================================================
    // Page compare
    always_comb begin
        addr_page = chk.addr[23:0] >> PAGE_BITS;
        bnd_page = chk.boundary >> PAGE_BITS;
        chk.hit = 1'b0;
        if (chk.boundary != BOUNDARY_RESET) begin
            if (chk.addr[31:24] == FLASH_PREFIX) begin
                chk.hit = (addr_page <= bnd_page);
            end
        end
    end

endmodule : page_protect_check

// File: logic/flash_page_write_protect.sv
// Decided for this implementation: the placing of the registers and the APB interface to the registers.
`timescale 1ns/10ps

module flash_page_write_protect #(
    parameter int PAGE_BITS = 12
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Flash write check
    input wire logic chk_valid,
    input wire logic [31:0] chk_addr,
    output logic chk_done,
    output logic chk_blocked
);
    import flash_wp_pkg::*;

    protect_check_if pc ();

    // Protect register
    logic unlock_reg;
    logic unlock_next;
    logic [23:0] boundary_reg;
    logic [23:0] boundary_next;

    // Unlock key sequence
    key_state_type key_reg;
    key_state_type key_next;

    // APB answer
    logic [31:0] prdata_reg;
    logic [31:0] prdata_next;
    logic pready_reg;
    logic pready_next;
    logic pslverr_reg;
    logic pslverr_next;

    // Flash write check answer
    logic done_reg;
    logic done_next;
    logic blocked_reg;
    logic blocked_next;

    // Decode and read views
    logic access;
    logic commit;
    logic mapped;
    logic key_write;
    logic protect_write;
    logic [31:0] protect_view;
    logic [31:0] status_view;

    // ==========================================================
    // Boundary checker
    assign pc.boundary = boundary_reg;
    assign pc.addr = chk_addr;

    page_protect_check #(
        .PAGE_BITS(PAGE_BITS)
    ) u_check (
        .chk(pc.checker_side)
    );

    // ==========================================================
    // APB handshake and decode
    assign access = psel && penable;
    assign commit = access && pready_reg;
    assign mapped = (paddr == PROTECT_OFFSET) || (paddr == KEY_OFFSET)
        || (paddr == STATUS_OFFSET);
    assign key_write = commit && pwrite && (paddr == KEY_OFFSET);
    assign protect_write = commit && pwrite && (paddr == PROTECT_OFFSET);

    // ==========================================================
    // Register read views
    always_comb begin
        protect_view = 32'h0000_0000;
        protect_view[UNLOCK_BIT] = unlock_reg;
        protect_view[BOUNDARY_WIDTH-1:0] = boundary_reg;
        status_view = 32'h0000_0000;
        status_view[0] = (key_reg == KEY_ARMED);
        status_view[1] = unlock_reg;
    end

    always_comb begin
        pready_next = access && !pready_reg;
        pslverr_next = access && !pready_reg && !mapped;
        prdata_next = 32'h0000_0000;
        if (access && !pready_reg && !pwrite) begin
            unique case (paddr)
                PROTECT_OFFSET: begin
                    prdata_next = protect_view;
                end
                STATUS_OFFSET: begin
                    prdata_next = status_view;
                end
                default: begin
                    prdata_next = 32'h0000_0000;
                end
            endcase
        end
    end

    // ==========================================================
    // Unlock key sequence
    always_comb begin
        key_next = key_reg;
        if (key_write) begin
            unique case (key_reg)
                KEY_IDLE: begin
                    key_next = (pwdata == KEY_FIRST_WORD) ? KEY_FIRST
                        : KEY_IDLE;
                end
                KEY_FIRST: begin
                    key_next = (pwdata == KEY_SECOND_WORD) ? KEY_ARMED
                        : KEY_IDLE;
                end
                KEY_ARMED: begin
                    key_next = (pwdata == KEY_FIRST_WORD) ? KEY_FIRST
                        : KEY_IDLE;
                end
                default: begin
                    key_next = KEY_IDLE;
                end
            endcase
        end
        if (protect_write) begin
            key_next = KEY_IDLE;
        end
    end

    // ==========================================================
    // Protect register
    always_comb begin
        unlock_next = unlock_reg;
        boundary_next = boundary_reg;
        if (protect_write && (key_reg == KEY_ARMED)
            && unlock_reg) begin
            boundary_next = pwdata[BOUNDARY_WIDTH-1:0];
            unlock_next = unlock_reg & pwdata[UNLOCK_BIT];
        end
    end

    // ==========================================================
    // Flash write check result
    always_comb begin
        done_next = chk_valid;
        blocked_next = chk_valid && pc.hit;
    end

    // ==========================================================
    // Protect register flip-flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            unlock_reg <= UNLOCK_RESET;
            boundary_reg <= BOUNDARY_RESET;
        end else begin
            unlock_reg <= unlock_next;
            boundary_reg <= boundary_next;
        end
    end

    // ==========================================================
    // Key sequence flip-flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            key_reg <= KEY_IDLE;
        end else begin
            key_reg <= key_next;
        end
    end

    // ==========================================================
    // APB answer flip-flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h0000_0000;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
        end else begin
            prdata_reg <= prdata_next;
            pready_reg <= pready_next;
            pslverr_reg <= pslverr_next;
        end
    end

    // ==========================================================
    // Check answer flip-flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done_reg <= 1'b0;
            blocked_reg <= 1'b0;
        end else begin
            done_reg <= done_next;
            blocked_reg <= blocked_next;
        end
    end

    // ==========================================================
    // Outputs
    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign chk_done = done_reg;
    assign chk_blocked = blocked_reg;

endmodule : flash_page_write_protect

// File: testbench/flash_page_write_protect_chk.sv
`timescale 1ns/10ps
// ======================
// Port watcher
module flash_page_write_protect_chk (
    // APB
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Flash check
    input wire logic chk_valid,
    input wire logic [31:0] chk_addr,
    input wire logic chk_done,
    input wire logic chk_blocked
);
    import flash_wp_pkg::*;
    logic rd_p;
    logic seen_reg;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    assign rd_p = pready && !pwrite && paddr == PROTECT_OFFSET;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seen_reg <= 1'b0;
        end else if (rd_p && !prdata[31]) begin
            seen_reg <= 1'b1;
        end
    end
    a_ready_after_wait: assert property (
        psel && penable && !pready |=> pready) else $error("no ready");
    a_ready_one_cycle: assert property (
        pready |=> !pready) else $error("long ready");
    a_unused_zero: assert property (
        rd_p |-> prdata[30:24] == 7'h00) else $error("bits 30:24");
    a_key_reads_zero: assert property (
        pready && !pwrite && paddr == KEY_OFFSET |-> prdata == 32'h0000_0000
        && !pslverr) else $error("key read");
    a_unlock_stays_clear: assert property (
        rd_p && seen_reg |-> !prdata[31]) else $error("unlock set");
    a_check_answer: assert property (
        chk_valid |=> chk_done) else $error("no done");
    a_outside_open: assert property (
        chk_valid && chk_addr[31:24] != FLASH_PREFIX |=> !chk_blocked)
        else $error("outside blocked");
    a_idle_quiet: assert property (
        !chk_valid |=> !chk_done && !chk_blocked) else $error("idle done");
endmodule : flash_page_write_protect_chk

bind flash_page_write_protect flash_page_write_protect_chk u_chk (.pclk,
    .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .chk_valid, .chk_addr, .chk_done, .chk_blocked);

// File: testbench/flash_page_write_protect_bench.sv
`timescale 1ns/10ps
module flash_page_write_protect_bench;
    import flash_wp_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, chk_valid = 1'b0, pready, pslverr, rerr;
    logic chk_done, chk_blocked;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, chk_addr = 32'h0000_0000;
    logic [31:0] prdata, rdata;
    int num_errors = 0, n_checks = 0;
    always #20 pclk = ~pclk;
    flash_page_write_protect DUT (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .chk_valid, .chk_addr,
        .chk_done, .chk_blocked);
    task finish_test;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : finish_test
    task cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            num_errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : cmp
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            num_errors++;
            finish_test;
        end
    endtask : apb
    task rd(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        cmp("prdata", e, rdata);
    endtask : rd
    task chk(input logic [31:0] a, input logic e);
        @(posedge pclk);
        chk_valid <= 1'b1;
        chk_addr <= a;
        @(posedge pclk);
        chk_valid <= 1'b0;
        #1;
        cmp("check", {30'h0000_0000, 1'b1, e}, {30'h0, chk_done, chk_blocked});
    endtask : chk
    task key_wr(input logic [31:0] d);
        apb(1'b1, KEY_OFFSET, KEY_FIRST_WORD);
        apb(1'b1, KEY_OFFSET, KEY_SECOND_WORD);
        apb(1'b1, PROTECT_OFFSET, d);
    endtask : key_wr
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        rd(PROTECT_OFFSET, 32'h8000_0000);
        apb(1'b1, PROTECT_OFFSET, 32'h0000_5000);
        rd(PROTECT_OFFSET, 32'h8000_0000);
        rd(STATUS_OFFSET, 32'h0000_0002);
        apb(1'b1, KEY_OFFSET, KEY_FIRST_WORD);
        apb(1'b1, KEY_OFFSET, KEY_SECOND_WORD);
        rd(STATUS_OFFSET, 32'h0000_0003);
        rd(KEY_OFFSET, 32'h0000_0000);
        key_wr(32'hff00_5800);
        rd(PROTECT_OFFSET, 32'h8000_5800);
        rd(STATUS_OFFSET, 32'h0000_0002);
        chk(32'h1d00_5fff, 1'b1);
        chk(32'h1d00_0000, 1'b1);
        chk(32'h1d00_6000, 1'b0);
        chk(32'h1c00_1000, 1'b0);
        apb(1'b0, 12'h00c, 32'h0000_0000);
        cmp("pslverr", 32'h0000_0001, {31'h0000_0000, rerr});
        key_wr(32'h8000_0000);
        chk(32'h1d00_0000, 1'b0);
        key_wr(32'h0000_3000);
        rd(PROTECT_OFFSET, 32'h0000_3000);
        key_wr(32'h8000_9000);
        rd(PROTECT_OFFSET, 32'h0000_3000);
        chk(32'h1d00_3000, 1'b1);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd(PROTECT_OFFSET, 32'h8000_0000);
        finish_test;
    end
endmodule : flash_page_write_protect_bench
